// [core/rtac_pkg.sv]
// Shared constants and types of the tag anticollision logic
package rtac_pkg;
  // ----------------------------------------
  // Widths and constants
  // ----------------------------------------
  localparam int RTAC_ID_W = 8;
  localparam int RTAC_SLOT_W = 4;
  localparam int RTAC_RNG_W = 16;
  localparam logic [15:0] RTAC_RNG_SEED = 16'hace1;
  localparam logic [15:0] RTAC_RNG_TAPS = 16'hb400;
  localparam logic [3:0] RTAC_SLOT0 = 4'h0;
  localparam logic [7:0] RTAC_ID_RST = 8'h00;
  localparam logic [1:0] RTAC_SYNC_RST = 2'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RTAC_READY = 3'b000,
    RTAC_INVENTORY = 3'b001,
    RTAC_SELECTED = 3'b010,
    RTAC_DESELECTED = 3'b011,
    RTAC_DEACTIVATED = 3'b100
  } rtac_state_t;

  typedef enum logic [2:0] {
    RTAC_CMD_INV_BEGIN = 3'b000,
    RTAC_CMD_SLOTTED_POLL = 3'b001,
    RTAC_CMD_SLOT_PROMPT = 3'b010,
    RTAC_CMD_SELECT = 3'b011,
    RTAC_CMD_COMPLETION = 3'b100,
    RTAC_CMD_OTHER = 3'b101
  } rtac_cmd_t;

  typedef struct packed {
    rtac_state_t state;
    logic [RTAC_ID_W-1:0] tag_identifier;
    logic answered;
    logic fresh;
    logic reply_valid;
    logic [RTAC_ID_W-1:0] reply_id;
  } rtac_core_t;

  typedef struct packed {
    logic [RTAC_RNG_W-1:0] lfsr;
  } rtac_rng_st_t;
endpackage

// [core/rtac_rng_if.sv]
// Random value carrier between the generator and the tag core
`timescale 1ns/1ps
`default_nettype none
interface rtac_rng_if;
  logic [7:0] rnd;
  modport src (output rnd);
  modport snk (input rnd);
endinterface
`default_nettype wire

// [core/rtac_lfsr.sv]
// Free-running pseudo-random source for the tag identifier
`timescale 1ns/1ps
`default_nettype none
module rtac_lfsr
  import rtac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  rtac_rng_if.src rng
);
  rtac_rng_st_t q, d;

  // ----------------------------------------
  // Galois shift, never stalls
  // ----------------------------------------
  always_comb begin
    d.lfsr = {1'b0, q.lfsr[RTAC_RNG_W-1:1]} ^ (q.lfsr[0] ? RTAC_RNG_TAPS : '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.lfsr <= RTAC_RNG_SEED;
    end else begin
      q <= d;
    end
  end

  // Low byte only; upper bits keep the sequence long
  assign rng.rnd = q.lfsr[7:0];

  lfsr_alive_a: assert property (@(posedge clk) disable iff (!rst_n)
    q.lfsr != '0) else $error("Random source stuck at zero");
endmodule
`default_nettype wire

// [core/rtac_tag.sv]
// Tag anticollision state machine with slotted reply logic
// Functional notes
// - Tag keeps an 8-bit identifier to be singled out among 256 tags.
// - Fresh random identifier on entering Ready and on inventory-begin in Inventory.
// - Identifier bits 0 to 3 form the slot selector in Inventory.
// - Each slotted poll redraws the 4-bit slot selector randomly.
// - Slotted poll answered with full identifier only when new selector is 0000.
// - Slot prompt answered only when selector equals the slot index.
// - Round has 16 slots: poll opens slot 0, prompts open 1 to 15.
// - Inventory-begin has no slotting; tag replies directly after it.
// - Poll and prompt answered only in Inventory; Ready tags ignore them.
// - Identifier sent at most once per round, in its own slot.
// - Reader is master; tag transmits only in reply to a command.
// - Select with matching identifier moves Inventory tag to Selected.
// - Selected tag ignores inventory-begin, poll and prompt.
// - Ready tag ignores every command except inventory-begin.
`timescale 1ns/1ps
`default_nettype none
module rtac_tag
  import rtac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire rtac_cmd_t cmd_code,
  input wire logic [RTAC_ID_W-1:0] cmd_arg,
  output logic reply_valid,
  output logic [RTAC_ID_W-1:0] reply_id,
  output logic [RTAC_ID_W-1:0] tag_identifier,
  output rtac_state_t tag_state
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= RTAC_SYNC_RST;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_q[1];

  // ----------------------------------------
  // Random source
  // ----------------------------------------
  rtac_rng_if rng ();

  rtac_lfsr u_rng (
    .clk(clk),
    .rst_n(rst_sync_n),
    .rng(rng)
  );

  function automatic logic slot_hit(input logic [RTAC_ID_W-1:0] id,
                                    input logic [RTAC_ID_W-1:0] idx);
    slot_hit = (id[RTAC_SLOT_W-1:0] == idx[RTAC_SLOT_W-1:0]);
  endfunction

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  rtac_core_t q, d;
  logic [RTAC_SLOT_W-1:0] new_slot;

  // Drawn at the taking edge, so the poll reply already carries the new nibble
  assign new_slot = rng.rnd[RTAC_SLOT_W-1:0];

  always_comb begin
    d = q;
    d.reply_valid = 1'b0;
    if (q.fresh) begin
      // Identifier cannot be random under reset, so draw it just after
      d.tag_identifier = rng.rnd;
      d.fresh = 1'b0;
    end
    if (cmd_valid) begin
      unique case (q.state)
        RTAC_READY: begin
          if (cmd_code == RTAC_CMD_INV_BEGIN) begin
            d.state = RTAC_INVENTORY;
            d.tag_identifier = rng.rnd;
            d.answered = 1'b0;
            d.reply_valid = 1'b1;
            d.reply_id = rng.rnd;
          end
        end
        RTAC_INVENTORY: begin
          unique case (cmd_code)
            RTAC_CMD_INV_BEGIN: begin
              d.tag_identifier = rng.rnd;
              d.answered = 1'b0;
              d.reply_valid = 1'b1;
              d.reply_id = rng.rnd;
            end
            RTAC_CMD_SLOTTED_POLL: begin
              d.tag_identifier[RTAC_SLOT_W-1:0] = new_slot;
              d.answered = (new_slot == RTAC_SLOT0);
              d.reply_valid = (new_slot == RTAC_SLOT0);
              d.reply_id = {q.tag_identifier[RTAC_ID_W-1:RTAC_SLOT_W], new_slot};
            end
            RTAC_CMD_SLOT_PROMPT: begin
              // Slot index comes from the reader; 1 to 15 in a normal round
              if (!q.answered && slot_hit(q.tag_identifier, cmd_arg)) begin
                d.answered = 1'b1;
                d.reply_valid = 1'b1;
                d.reply_id = q.tag_identifier;
              end
            end
            RTAC_CMD_SELECT: begin
              if (cmd_arg == q.tag_identifier) begin
                d.state = RTAC_SELECTED;
              end
            end
            default: begin
            end
          endcase
        end
        RTAC_SELECTED: begin
          // Anticollision commands are silently dropped here
          if (cmd_code == RTAC_CMD_SELECT && cmd_arg != q.tag_identifier) begin
            d.state = RTAC_DESELECTED;
          end else if (cmd_code == RTAC_CMD_COMPLETION) begin
            d.state = RTAC_DEACTIVATED;
          end
        end
        RTAC_DESELECTED: begin
          if (cmd_code == RTAC_CMD_SELECT && cmd_arg == q.tag_identifier) begin
            d.state = RTAC_SELECTED;
          end
        end
        RTAC_DEACTIVATED: begin
          // Only loss of power leaves this state
        end
        default: begin
          d.state = RTAC_READY;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q.state <= RTAC_READY;
      q.tag_identifier <= RTAC_ID_RST;
      q.answered <= 1'b0;
      q.fresh <= 1'b1;
      q.reply_valid <= 1'b0;
      q.reply_id <= RTAC_ID_RST;
    end else begin
      q <= d;
    end
  end

  assign reply_valid = q.reply_valid;
  assign reply_id = q.reply_id;
  assign tag_identifier = q.tag_identifier;
  assign tag_state = q.state;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  // Anticollision commands only count in Inventory
  logic inv_cmd;
  assign inv_cmd = cmd_valid && q.state == RTAC_INVENTORY;

  id_load_a: assert property ($rose(rst_sync_n) |=>
    q.tag_identifier == $past(rng.rnd) || q.state != RTAC_READY)
    else $error("Identifier not drawn after reset");
  init_reply_a: assert property (cmd_valid && cmd_code == RTAC_CMD_INV_BEGIN
    && (q.state == RTAC_READY || q.state == RTAC_INVENTORY)
    |=> reply_valid && reply_id == tag_identifier && tag_state == RTAC_INVENTORY)
    else $error("Inventory-begin not answered");
  poll_redraw_a: assert property (inv_cmd && cmd_code == RTAC_CMD_SLOTTED_POLL
    |=> tag_identifier[3:0] == $past(new_slot)
    && tag_identifier[7:4] == $past(q.tag_identifier[7:4]))
    else $error("Slot selector not redrawn");
  poll_reply_a: assert property (inv_cmd && cmd_code == RTAC_CMD_SLOTTED_POLL
    |=> reply_valid == (tag_identifier[3:0] == RTAC_SLOT0))
    else $error("Poll reply does not follow slot 0");
  prompt_reply_a: assert property (inv_cmd && cmd_code == RTAC_CMD_SLOT_PROMPT
    && !q.answered |=> reply_valid == slot_hit(tag_identifier, $past(cmd_arg)))
    else $error("Prompt reply does not follow slot match");
  round_once_a: assert property (inv_cmd && cmd_code == RTAC_CMD_SLOT_PROMPT
    && q.answered |=> !reply_valid)
    else $error("Second reply in one round");
  ready_quiet_a: assert property (cmd_valid && q.state == RTAC_READY
    && cmd_code != RTAC_CMD_INV_BEGIN |=> !reply_valid && tag_state == RTAC_READY)
    else $error("Ready tag reacted to command");
  select_enter_a: assert property (inv_cmd && cmd_code == RTAC_CMD_SELECT
    |=> tag_state == ($past(cmd_arg) == tag_identifier ? RTAC_SELECTED : RTAC_INVENTORY))
    else $error("Select handling wrong in Inventory");
  selected_mute_a: assert property (q.state == RTAC_SELECTED |=> !reply_valid)
    else $error("Selected tag answered");
  reply_cause_a: assert property (reply_valid |-> $past(cmd_valid))
    else $error("Reply without command");
  id_hold_a: assert property (!q.fresh && !(cmd_valid && (cmd_code == RTAC_CMD_INV_BEGIN
    || cmd_code == RTAC_CMD_SLOTTED_POLL)) |=> $stable(tag_identifier))
    else $error("Identifier changed without a draw");
  park_quiet_a: assert property (q.state == RTAC_DESELECTED
    || q.state == RTAC_DEACTIVATED |=> !reply_valid)
    else $error("Parked tag answered");

  poll_hit_c: cover property (inv_cmd && cmd_code == RTAC_CMD_SLOTTED_POLL ##1 reply_valid);
  prompt_hit_c: cover property (inv_cmd && cmd_code == RTAC_CMD_SLOT_PROMPT ##1 reply_valid);
  selected_c: cover property (q.state == RTAC_INVENTORY ##1 q.state == RTAC_SELECTED);
  deact_c: cover property (q.state == RTAC_DEACTIVATED);
  deselect_c: cover property (q.state == RTAC_SELECTED ##1 q.state == RTAC_DESELECTED);
endmodule
`default_nettype wire

// [test/rtac_reader.sv]
// Reader model that issues tag commands and captures replies
`timescale 1ns/1ps
`default_nettype none
module rtac_reader
  import rtac_pkg::*;
(
  input wire logic clk,
  input wire logic reply_valid,
  input wire logic [RTAC_ID_W-1:0] reply_id,
  output var logic cmd_valid,
  output var rtac_cmd_t cmd_code,
  output var logic [RTAC_ID_W-1:0] cmd_arg
);
  // ----------------------------------------
  // Command issue
  // ----------------------------------------
  initial begin
    cmd_valid = 1'b0;
    cmd_code = RTAC_CMD_OTHER;
    cmd_arg = 8'h00;
  end
  // Reader starts every exchange; reply sampled in its single cycle
  task automatic issue(input rtac_cmd_t code, input logic [7:0] arg,
                       output logic got, output logic [7:0] id);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_arg <= arg;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= RTAC_CMD_OTHER;
    cmd_arg <= ~arg; // Stale argument must not be trusted
    #1;
    got = reply_valid;
    id = reply_id;
  endtask
  // Poll opens slot 0, prompts 1 to 15 in ascending order
  task automatic round(output int hits, output logic [3:0] slot,
                       output logic [7:0] id);
    logic got;
    logic [7:0] rid;
    hits = 0;
    slot = 4'h0;
    id = 8'h00;
    issue(RTAC_CMD_SLOTTED_POLL, 8'h00, got, rid);
    if (got) begin
      hits++;
      id = rid;
    end
    for (int s = 1; s < 16; s++) begin
      issue(RTAC_CMD_SLOT_PROMPT, 8'(s), got, rid);
      if (got) begin
        hits++;
        slot = 4'(s);
        id = rid;
      end
    end
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench of the tag anticollision logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtac_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid;
  rtac_cmd_t cmd_code;
  logic [7:0] cmd_arg;
  logic reply_valid;
  logic [7:0] reply_id;
  logic [7:0] tag_identifier;
  rtac_state_t tag_state;
  int n_fail = 0;
  int check_count = 0;
  logic got;
  logic [7:0] id;
  always #50 clk = ~clk;
  rtac_tag i_rtac_tag (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg(cmd_arg), .reply_valid(reply_valid), .reply_id(reply_id),
    .tag_identifier(tag_identifier), .tag_state(tag_state));
  rtac_reader i_rtac_reader (.clk(clk), .reply_valid(reply_valid), .reply_id(reply_id),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic send(input rtac_cmd_t code, input logic [7:0] arg);
    i_rtac_reader.issue(code, arg, got, id);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ready;
    chk(tag_state === RTAC_READY && reply_valid === 1'b0, "reset state");
    chk(tag_identifier === RTAC_ID_RST, "reset identifier");
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(tag_identifier === RTAC_RNG_SEED[7:0], "no draw after reset");
    send(RTAC_CMD_SLOTTED_POLL, 8'h00);
    chk(got === 1'b0, "ready answered poll");
    for (int s = 0; s < 16; s++) begin
      send(RTAC_CMD_SLOT_PROMPT, 8'(s));
      chk(got === 1'b0, "ready answered prompt");
    end
    send(RTAC_CMD_SELECT, tag_identifier);
    send(RTAC_CMD_COMPLETION, 8'h00);
    chk(got === 1'b0 && tag_state === RTAC_READY, "ready left state");
  endtask
  task automatic t_begin;
    for (int k = 0; k < 2; k++) begin
      send(RTAC_CMD_INV_BEGIN, 8'h00);
      chk(got === 1'b1 && id === tag_identifier, "begin reply");
      chk(tag_state === RTAC_INVENTORY, "begin state");
    end
  endtask
  task automatic t_rounds;
    int hits;
    logic [3:0] slot;
    logic [3:0] hi;
    for (int r = 0; r < 12; r++) begin
      // Bench plays a crowded field: a lone begin reply still goes to polling
      send(RTAC_CMD_INV_BEGIN, 8'h00);
      chk(got === 1'b1 && id === tag_identifier, "begin before round");
      hi = tag_identifier[7:4];
      i_rtac_reader.round(hits, slot, id);
      chk(hits === 1, "not one reply per round");
      chk(tag_identifier[7:4] === hi, "poll touched upper bits");
      chk(slot === tag_identifier[3:0] && id === tag_identifier, "wrong slot");
    end
  endtask
  task automatic t_select;
    send(RTAC_CMD_SELECT, ~tag_identifier);
    chk(tag_state === RTAC_INVENTORY, "mismatch selected");
    send(RTAC_CMD_SELECT, tag_identifier);
    chk(tag_state === RTAC_SELECTED, "match not selected");
    send(RTAC_CMD_INV_BEGIN, 8'h00);
    chk(got === 1'b0, "selected answered begin");
    send(RTAC_CMD_SLOTTED_POLL, 8'h00);
    chk(got === 1'b0, "selected answered poll");
    send(RTAC_CMD_SLOT_PROMPT, {4'h0, tag_identifier[3:0]});
    chk(got === 1'b0 && tag_state === RTAC_SELECTED, "selected answered prompt");
    send(RTAC_CMD_SELECT, ~tag_identifier);
    chk(tag_state === RTAC_DESELECTED, "not parked");
    send(RTAC_CMD_INV_BEGIN, 8'h00);
    chk(got === 1'b0, "deselected answered begin");
    send(RTAC_CMD_SELECT, tag_identifier);
    chk(tag_state === RTAC_SELECTED, "not reselected");
    send(RTAC_CMD_COMPLETION, 8'h00);
    send(RTAC_CMD_SELECT, tag_identifier);
    chk(got === 1'b0 && tag_state === RTAC_DEACTIVATED, "deactivated reacted");
  endtask
  task automatic t_power;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(tag_state === RTAC_READY && tag_identifier === RTAC_ID_RST, "no ready");
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(tag_identifier === RTAC_RNG_SEED[7:0], "no redraw after reset");
    send(RTAC_CMD_INV_BEGIN, 8'h00);
    chk(got === 1'b1 && tag_state === RTAC_INVENTORY, "begin after reset");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    t_ready;
    t_begin;
    t_rounds;
    t_select;
    t_power;
    wrap_up;
  end
endmodule
`default_nettype wire
